//--- dec_pkg.sv
`default_nettype none
package dec_pkg;
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] WPT_PC_AHEAD = 3'h5;
    localparam logic [2:0] PC_AHEAD_NONE = 3'h0;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_BREAK = 2'h1;
    localparam logic [1:0] CAUSE_WATCH = 2'h2;
    localparam logic [1:0] CAUSE_REQUEST = 2'h3;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_BKPT_ENTRY = 3'h1,
        ST_WPT_WAIT = 3'h2,
        ST_WPT_EXC = 3'h3,
        ST_REQ_DRAIN = 3'h4,
        ST_HALTED = 3'h5
    } dec_state_t;
endpackage
`default_nettype wire

//--- dec_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dec_sync (
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic asyncIn, // Level from another timing domain
    output logic syncOut // Level safe to use in the core domain
);
    logic [dec_pkg::SYNC_STAGES-1:0] stage_q;

    // Stage 0 feeds only stage 1; syncOut is the last stage
    always_ff @(posedge clk) begin
        if (rst) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[dec_pkg::SYNC_STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = stage_q[dec_pkg::SYNC_STAGES-1];
endmodule // dec_sync
`default_nettype wire

//--- dec_entry_control.sv
// Functional notes
// - External breakpoint ORed with internal breakpoint before reaching core control.
// - Fetched instruction is latched at the end of its fetch cycle.
// - Breakpointed instruction enters Execute with its state changes suppressed.
// - Debug entry sequence starts from latched breakpoint, overlapping its Execute.
// - Prefetch abort on a breakpointed instruction wins; breakpoint ignored.
// - Breakpoint beats software interrupt or undefined instruction.
// - Interrupt at boundary with breakpointed instruction wins; instruction discarded.
// - Debug state disables interrupt recognition, status flags untouched.
// - After watchpoint the next instruction completes; entry is imprecise.
// - Instruction following the completing one is not executed.
// - Watchpoint entry leaves PC five instructions ahead.
// - Aborting watchpointed access: abort entry first, then debug state.
// - Pending interrupt at watchpoint: interrupt entry first, then debug.
// - Debug request from on-chip unit or external pin, synchronised.
// - Synchronised debug request beats pending interrupt.
// - After request, stop issue; enter debug once Execute instruction retires.
// - In debug state both memory interfaces signal internal cycles.
// - In debug state aborts and interrupts are ignored.
// - Acknowledge output high whenever in debug state.
// - On-chip debug unit facilities used only while enable input is high.
`timescale 1ns/100ps
`default_nettype none
module dec_entry_control (
    input wire logic clk, // Core clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic ext_breakpoint_in, // Breakpoint from external comparators
    input wire logic intBreakpointIn, // Breakpoint from on-chip debug unit
    input wire logic ext_watchpoint_in, // Watchpoint from external comparators
    input wire logic intWatchpointIn, // Watchpoint from on-chip debug unit
    input wire logic ext_debug_request_in, // Asynchronous debug request pin
    input wire logic intDebugRequestIn, // Debug request from on-chip debug unit
    input wire logic debug_facility_enable_in, // On-chip debug unit enable
    input wire logic fetchLatchIn, // Instruction fetched and latched this cycle
    input wire logic prefetchAbortIn, // Abort tag of the instruction in Decode
    input wire logic execEnterIn, // Decode instruction moves to Execute
    input wire logic dataAccessIn, // Data access completes this cycle
    input wire logic dataAbortIn, // That data access aborts
    input wire logic nextDoneIn, // Instruction after the watched access completed
    input wire logic excEntryDoneIn, // Exception entry sequence finished
    input wire logic execDrainedIn, // Execute instruction finished Memory and Write
    input wire logic irqPendingIn, // Interrupt or fast_interrupt pending
    input wire logic restartIn, // Leave debug state
    output logic coreBreakpoint_q, // Merged breakpoint for the instruction latched
    output logic suppressExec_q, // Execute instruction makes no state change
    output logic discardInstr_q, // Breakpointed instruction dropped for interrupt
    output logic stallIssue_q, // No issue into Execute
    output logic irqRecognize_q, // Interrupts may be recognised
    output logic abortRecognize_q, // Aborts may be recognised
    output logic memInternal_q, // Both memory interfaces show internal cycles
    output logic debug_state_ack_out, // High in debug state
    output logic [1:0] entryCause_q, // Cause of the latest entry
    output logic [2:0] pcAhead_q // Instructions the PC runs ahead on entry
);
    dec_pkg::dec_state_t state_q, state_d;
    logic reqSync, reqRaw, bkptMerged, wptHit;
    logic fetchLatch_q, bkptTag_q, bkptExec;
    logic doSuppress, doDiscard;

    // Decoded from the next state so the outputs settle with the state register
    function automatic logic isStalled(input dec_pkg::dec_state_t st);
        return (st == dec_pkg::ST_REQ_DRAIN) || (st == dec_pkg::ST_HALTED);
    endfunction

    function automatic logic isHalted(input dec_pkg::dec_state_t st);
        return st == dec_pkg::ST_HALTED;
    endfunction

    // Internal sources are honoured only with the facility enabled
    assign bkptMerged = ext_breakpoint_in | (intBreakpointIn & debug_facility_enable_in);
    assign wptHit = dataAccessIn & (ext_watchpoint_in | (intWatchpointIn & debug_facility_enable_in));
    assign reqRaw = ext_debug_request_in | (intDebugRequestIn & debug_facility_enable_in);

    dec_sync u_dec_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn(reqRaw),
        .syncOut(reqSync)
    );

    // Breakpoint sampled one cycle after the fetch latch
    always_ff @(posedge clk) begin
        if (rst) begin
            fetchLatch_q <= 1'h0;
        end else begin
            fetchLatch_q <= fetchLatchIn;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bkptTag_q <= 1'h0;
        end else if (fetchLatch_q) begin
            bkptTag_q <= bkptMerged;
        end else if (execEnterIn) begin
            bkptTag_q <= 1'h0;
        end
    end

    // Tag is dropped when the instruction carries a prefetch abort
    assign bkptExec = execEnterIn & bkptTag_q & ~prefetchAbortIn;

    always_comb begin
        state_d = state_q;
        doSuppress = 1'h0;
        doDiscard = 1'h0;
        unique case (state_q)
            dec_pkg::ST_RUN: begin
                if (reqSync) begin
                    state_d = dec_pkg::ST_REQ_DRAIN;
                end else if (wptHit) begin
                    if (dataAbortIn || irqPendingIn) begin
                        state_d = dec_pkg::ST_WPT_EXC;
                    end else begin
                        state_d = dec_pkg::ST_WPT_WAIT;
                    end
                end else if (bkptExec) begin
                    if (irqPendingIn) begin
                        doDiscard = 1'h1;
                    end else begin
                        doSuppress = 1'h1;
                        state_d = dec_pkg::ST_BKPT_ENTRY;
                    end
                end
            end
            dec_pkg::ST_BKPT_ENTRY: begin
                state_d = dec_pkg::ST_HALTED;
            end
            dec_pkg::ST_WPT_WAIT: begin
                if (nextDoneIn) begin
                    doSuppress = 1'h1;
                    state_d = dec_pkg::ST_HALTED;
                end
            end
            dec_pkg::ST_WPT_EXC: begin
                if (excEntryDoneIn) begin
                    state_d = dec_pkg::ST_HALTED;
                end
            end
            dec_pkg::ST_REQ_DRAIN: begin
                if (execDrainedIn) begin
                    state_d = dec_pkg::ST_HALTED;
                end
            end
            dec_pkg::ST_HALTED: begin
                if (restartIn) begin
                    state_d = dec_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = dec_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= dec_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            coreBreakpoint_q <= 1'h0;
            suppressExec_q <= 1'h0;
            discardInstr_q <= 1'h0;
        end else begin
            coreBreakpoint_q <= fetchLatch_q & bkptMerged;
            suppressExec_q <= doSuppress;
            discardInstr_q <= doDiscard;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stallIssue_q <= 1'h0;
            irqRecognize_q <= 1'h1;
            abortRecognize_q <= 1'h1;
            memInternal_q <= 1'h0;
            debug_state_ack_out <= 1'h0;
        end else begin
            stallIssue_q <= isStalled(state_d);
            // Interrupts stay out for the whole drain, yet stay open for exception entry
            irqRecognize_q <= !isStalled(state_d);
            abortRecognize_q <= !isHalted(state_d);
            memInternal_q <= isHalted(state_d);
            debug_state_ack_out <= isHalted(state_d);
        end
    end

    // Cause and PC offset are captured on the edge that leaves RUN
    always_ff @(posedge clk) begin
        if (rst) begin
            entryCause_q <= dec_pkg::CAUSE_NONE;
            pcAhead_q <= dec_pkg::PC_AHEAD_NONE;
        end else if (state_q == dec_pkg::ST_RUN && state_d != dec_pkg::ST_RUN) begin
            if (state_d == dec_pkg::ST_REQ_DRAIN) begin
                entryCause_q <= dec_pkg::CAUSE_REQUEST;
                pcAhead_q <= dec_pkg::PC_AHEAD_NONE;
            end else if (state_d == dec_pkg::ST_BKPT_ENTRY) begin
                entryCause_q <= dec_pkg::CAUSE_BREAK;
                pcAhead_q <= dec_pkg::PC_AHEAD_NONE;
            end else begin
                entryCause_q <= dec_pkg::CAUSE_WATCH;
                pcAhead_q <= dec_pkg::WPT_PC_AHEAD;
            end
        end
    end

    AST_BKPT_MERGE: assert property (@(posedge clk) disable iff (rst)
        fetchLatch_q && ext_breakpoint_in |=> coreBreakpoint_q)
        else $error("external breakpoint not merged");

    AST_INT_GATED: assert property (@(posedge clk) disable iff (rst)
        fetchLatch_q && !ext_breakpoint_in && !debug_facility_enable_in |=> !coreBreakpoint_q)
        else $error("internal breakpoint used while disabled");

    AST_BKPT_ENTRY: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_RUN && !reqSync && !wptHit && bkptExec && !irqPendingIn
        |=> suppressExec_q ##1 debug_state_ack_out)
        else $error("breakpoint entry sequence wrong");

    AST_PABT_WINS: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_RUN && !reqSync && !wptHit && execEnterIn && prefetchAbortIn
        |=> !suppressExec_q && !discardInstr_q)
        else $error("breakpoint taken despite prefetch abort");

    AST_IRQ_DISCARD: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_RUN && !reqSync && !wptHit && bkptExec && irqPendingIn
        |=> discardInstr_q && !debug_state_ack_out)
        else $error("interrupt did not discard breakpointed instruction");

    AST_WPT_PC: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_RUN && !reqSync && wptHit |=> pcAhead_q == dec_pkg::WPT_PC_AHEAD)
        else $error("watchpoint PC offset not five");

    AST_WPT_EXC_FIRST: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_WPT_EXC && !excEntryDoneIn |=> !debug_state_ack_out)
        else $error("debug entered before exception entry");

    AST_REQ_STALL: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_RUN && reqSync |=> stallIssue_q && !irqRecognize_q)
        else $error("request did not stall issue");

    AST_HALT_ISOLATE: assert property (@(posedge clk) disable iff (rst)
        debug_state_ack_out |-> memInternal_q && !irqRecognize_q && !abortRecognize_q)
        else $error("core not isolated in debug state");

    AST_REQ_SYNC: assert property (@(posedge clk) disable iff (rst)
        $rose(reqSync) |-> $past(reqRaw, 2))
        else $error("request used without two-stage sync");

    AST_BKPT_SAMPLE: assert property (@(posedge clk) disable iff (rst)
        fetchLatch_q |=> bkptTag_q == $past(bkptMerged))
        else $error("breakpoint not sampled in the cycle after the fetch latch");

    AST_BKPT_HALT: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_BKPT_ENTRY |=> debug_state_ack_out)
        else $error("breakpoint entry sequence did not reach debug state");

    AST_ENTRY_IRQ_OFF: assert property (@(posedge clk) disable iff (rst)
        $rose(debug_state_ack_out) |-> !irqRecognize_q)
        else $error("interrupts still recognised on debug entry");

    AST_WPT_HOLD: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_WPT_WAIT && !nextDoneIn |=> !debug_state_ack_out && state_q == dec_pkg::ST_WPT_WAIT)
        else $error("watchpoint entry before the next instruction completed");

    AST_WPT_NEXT: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_WPT_WAIT && nextDoneIn |=> suppressExec_q && debug_state_ack_out)
        else $error("following instruction not suppressed on watchpoint entry");

    AST_WPT_IRQ_FIRST: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_RUN && !reqSync && wptHit && irqPendingIn
        |=> state_q == dec_pkg::ST_WPT_EXC && irqRecognize_q)
        else $error("pending interrupt not taken before watchpoint entry");

    AST_WPT_ABORT_FIRST: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_RUN && !reqSync && wptHit && dataAbortIn
        |=> state_q == dec_pkg::ST_WPT_EXC && abortRecognize_q)
        else $error("aborting watched access not taken before debug entry");

    AST_REQ_FIRST: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_RUN && reqSync && (wptHit || bkptExec)
        |=> state_q == dec_pkg::ST_REQ_DRAIN && !suppressExec_q && !discardInstr_q)
        else $error("request lost priority to another entry source");

    AST_DRAIN_WAIT: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_REQ_DRAIN && !execDrainedIn |=> !debug_state_ack_out && stallIssue_q && !irqRecognize_q)
        else $error("debug state entered before the Execute instruction retired");

    AST_ACK_STATE: assert property (@(posedge clk) disable iff (rst)
        debug_state_ack_out == (state_q == dec_pkg::ST_HALTED))
        else $error("acknowledge does not follow debug state");

    AST_EXIT: assert property (@(posedge clk) disable iff (rst)
        state_q == dec_pkg::ST_HALTED && restartIn
        |=> !debug_state_ack_out && irqRecognize_q && abortRecognize_q && !memInternal_q)
        else $error("core not released on leaving debug state");
endmodule // dec_entry_control
`default_nettype wire

//--- dec_debug_source.sv
`timescale 1ns/100ps
`default_nettype none
module dec_debug_source (
    input wire logic clk, // Core clock
    input wire logic fetchLatchIn, // Core latched an instruction
    input wire logic dataAccessIn, // Data access completes
    input wire logic bkptArm, // Comparator matches the next fetch
    input wire logic wptArm, // Comparator matches the next data access
    input wire logic reqArm, // Debugger wants the core halted
    output logic ext_breakpoint_in, // Breakpoint to the core
    output logic ext_watchpoint_in, // Watchpoint to the core
    output logic ext_debug_request_in // Asynchronous halt request
);
    initial begin
        ext_breakpoint_in = 1'b0;
        ext_debug_request_in = 1'b0;
    end
    // Match valid in the cycle after the fetch latch, gone after it
    always @(posedge clk) begin
        ext_breakpoint_in <= fetchLatchIn & bkptArm;
    end
    assign ext_watchpoint_in = dataAccessIn & wptArm;
    // Request comes from an unrelated clock, so it moves off the core edge
    always @(reqArm) begin
        ext_debug_request_in <= #17 reqArm;
    end
endmodule // dec_debug_source
`default_nettype wire

//--- test_debug_entry_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_debug_entry_control;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic intBkpt = 1'b0, intWpt = 1'b0, intReq = 1'b0, enable = 1'b1;
    logic pAbt = 1'b0, dAbt = 1'b0, irq = 1'b0, bkptArm = 1'b0, wptArm = 1'b0, reqArm = 1'b0;
    logic [6:0] pls = 7'h00;
    wire logic extBkpt, extWpt, extReq;
    wire logic [12:0] obs;
    int failures = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    dec_debug_source u_dec_debug_source (.clk(clk), .fetchLatchIn(pls[0]), .dataAccessIn(pls[2]),
        .bkptArm(bkptArm), .wptArm(wptArm), .reqArm(reqArm), .ext_breakpoint_in(extBkpt),
        .ext_watchpoint_in(extWpt), .ext_debug_request_in(extReq));
    dec_entry_control u_dec_entry_control (.clk(clk), .rst(rst), .ext_breakpoint_in(extBkpt),
        .intBreakpointIn(intBkpt), .ext_watchpoint_in(extWpt), .intWatchpointIn(intWpt),
        .ext_debug_request_in(extReq), .intDebugRequestIn(intReq), .debug_facility_enable_in(enable),
        .fetchLatchIn(pls[0]), .prefetchAbortIn(pAbt), .execEnterIn(pls[1]), .dataAccessIn(pls[2]),
        .dataAbortIn(dAbt), .nextDoneIn(pls[3]), .excEntryDoneIn(pls[4]), .execDrainedIn(pls[5]),
        .irqPendingIn(irq), .restartIn(pls[6]), .coreBreakpoint_q(obs[0]), .suppressExec_q(obs[1]),
        .discardInstr_q(obs[2]), .stallIssue_q(obs[3]), .irqRecognize_q(obs[4]), .abortRecognize_q(obs[5]),
        .memInternal_q(obs[6]), .debug_state_ack_out(obs[7]), .entryCause_q(obs[9:8]), .pcAhead_q(obs[12:10]));
    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        pls[i] <= 1'b1;
        @(posedge clk);
        pls[i] <= 1'b0;
    endtask
    // Poll a flag for up to n cycles, then judge it
    task automatic waitFor(input string nm, input int b, input logic v, input int n);
        int k;
        k = 0;
        #1;
        while (obs[b] !== v && k < n) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(nm, {2'h0, v}, {2'h0, obs[b]});
    endtask
    // Flag must stay low for n cycles
    task automatic quiet(input string nm, input int b, input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1;
            seen = seen | (obs[b] !== 1'b0);
        end
        chk(nm, 3'h0, {2'h0, seen});
    endtask
    task automatic leave();
        pulse(6);
        waitFor("ack", 7, 1'b0, 2);
    endtask
    task automatic bkptEntry();
        bkptArm <= 1'b1;
        pulse(0);
        waitFor("coreBreakpoint", 0, 1'b1, 3);
        bkptArm <= 1'b0;
        pulse(1);
        waitFor("suppressExec", 1, 1'b1, 2);
        waitFor("ack", 7, 1'b1, 2);
        chk("memInternal", 3'h1, {2'h0, obs[6]});
        chk("irqRecognize", 3'h0, {2'h0, obs[4]});
        chk("abortRecognize", 3'h0, {2'h0, obs[5]});
        chk("cause", {1'b0, dec_pkg::CAUSE_BREAK}, {1'b0, obs[9:8]});
        leave();
    endtask
    task automatic bkptGated();
        enable <= 1'b0;
        intBkpt <= 1'b1;
        pulse(0);
        quiet("coreBreakpoint", 0, 3);
        enable <= 1'b1;
        pulse(0);
        waitFor("coreBreakpoint", 0, 1'b1, 3);
        intBkpt <= 1'b0;
        pulse(1);
        waitFor("ack", 7, 1'b1, 3);
        leave();
    endtask
    task automatic bkptAbort();
        bkptArm <= 1'b1;
        pAbt <= 1'b1;
        pulse(0);
        pulse(1);
        quiet("ack", 7, 5);
        pAbt <= 1'b0;
        irq <= 1'b1;
        pulse(0);
        pulse(1);
        waitFor("discardInstr", 2, 1'b1, 2);
        quiet("ack", 7, 4);
        irq <= 1'b0;
        pulse(0);
        bkptArm <= 1'b0;
        pulse(1);
        waitFor("ack", 7, 1'b1, 3);
        leave();
    endtask
    task automatic watchNext();
        wptArm <= 1'b1;
        pulse(2);
        wptArm <= 1'b0;
        #1;
        chk("pcAhead", dec_pkg::WPT_PC_AHEAD, obs[12:10]);
        chk("cause", {1'b0, dec_pkg::CAUSE_WATCH}, {1'b0, obs[9:8]});
        quiet("ack", 7, 3);
        pulse(3);
        waitFor("ack", 7, 1'b1, 2);
        chk("suppressExec", 3'h1, {2'h0, obs[1]});
        leave();
    endtask
    task automatic watchExc(input logic viaIrq);
        wptArm <= 1'b1;
        dAbt <= ~viaIrq;
        irq <= viaIrq;
        pulse(2);
        wptArm <= 1'b0;
        dAbt <= 1'b0;
        pulse(3);
        quiet("ack", 7, 3);
        irq <= 1'b0;
        pulse(4);
        waitFor("ack", 7, 1'b1, 2);
        leave();
    endtask
    task automatic request(input logic onChip);
        irq <= 1'b1;
        intReq <= onChip;
        reqArm <= ~onChip;
        if (onChip) begin
            enable <= 1'b0;
            quiet("stallIssue", 3, 6);
            enable <= 1'b1;
        end
        waitFor("stallIssue", 3, 1'b1, 6);
        chk("irqRecognize", 3'h0, {2'h0, obs[4]});
        quiet("ack", 7, 3);
        intReq <= 1'b0;
        reqArm <= 1'b0;
        irq <= 1'b0;
        pulse(5);
        waitFor("ack", 7, 1'b1, 2);
        chk("cause", {1'b0, dec_pkg::CAUSE_REQUEST}, {1'b0, obs[9:8]});
        repeat (4) @(posedge clk);
        leave();
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("resetRecognize", 3'h3, {1'b0, obs[5:4]});
        chk("resetAck", 3'h0, {2'h0, obs[7]});
        bkptEntry();
        bkptGated();
        bkptAbort();
        watchNext();
        watchExc(1'b0);
        watchExc(1'b1);
        request(1'b0);
        request(1'b1);
        wrap_up();
    end
endmodule // test_debug_entry_control
`default_nettype wire
